// [rtl/csc_core_end.sv]
/*
  Converter core end of the video stream link: accepts packed pixels,
  buffers them in a small FIFO, repacks them and sends them on, with
  frame marks passed through and line marks regenerated from the built-in frame size.
  Assumes stream inputs synchronous to clock and a peer that keeps
  the core reset low long enough.
*/
// Contract
// - Sample inputs and update outputs on rising edges
// - Enable low freezes state and output levels
// - Enable low ignores all inputs but reset
// - Core reset active low, synchronous, beats enable
// - Peer holds core reset low 32 cycles
// - Control side keeps own clock and reset
// - Source packs components, zero pads top bits
// - Core packs output components, zero pads top
// - Transfer needs ready, valid, enable, no reset
// - Only active pixels cross the stream
// - Source holds word steady until accepted
// - Source keeps valid until transfer completes
// - Sink ready may come before or after
// - Sink should drive ready independent of valid; the READY_REGD peer sink registers ready from outValid
// - Frame start marks exactly the first pixel
// - Frame start may rise early while valid low
// - Line end marks exactly the last pixel
// - Fixed build uses built-in frame size
// - Interrupt request only with control interface
// - Six-bit interrupt bus only when selected
// - Control reset also resets stream, resynchronised
`timescale 1ns/1ps
`default_nettype none
module csc_core_end
  import csc_stream_pkg::*;
#(
  parameter int CW = COMP_W,
  parameter int COLS = ACTIVE_COLS,
  parameter int ROWS = ACTIVE_ROWS,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int HAS_CTRL = 0,
  parameter int HAS_INTC = 0
)(
  input wire logic clock,
  input wire logic rst,
  csc_stream_if.dev link,
  input wire logic ctrlRstN,
  output logic irqReq,
  output logic [INTC_W-1:0] extIrqCtrlBus,
  output logic [$clog2(COLS)-1:0] colPos,
  output logic [$clog2(ROWS)-1:0] rowPos,
  output logic lineErr
);
  localparam int PW = NUM_COMP * CW;
  localparam int WW = csc_word_w(CW);
  localparam int EW = PW + 2;
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int NW = $clog2(DEPTH + 1);
  localparam int XW = $clog2(COLS);
  localparam int YW = $clog2(ROWS);
  localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);
  localparam logic [NW-1:0] FULL_COUNT = NW'(DEPTH);
  localparam logic [XW-1:0] LAST_COL = XW'(COLS - 1);
  localparam logic [YW-1:0] LAST_ROW = YW'(ROWS - 1);

  logic ctrlMeta_r;
  logic ctrlSync_r;
  logic coreReset;
  logic runEn;
  logic push;
  logic pop;
  logic [EW-1:0] mem_r [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [NW-1:0] count_r;
  logic [NW-1:0] count_nxt;
  logic [XW-1:0] col_r;
  logic [YW-1:0] row_r;
  logic [XW-1:0] curCol;
  logic [YW-1:0] curRow;
  logic lineEndCalc;
  logic frameEndCalc;
  logic lineErr_r;
  logic frameDone_r;
  logic [EW-1:0] head;
  logic [PW-1:0] inPix;
  logic [PW-1:0] outPix;

  // Control reset brought into the core clock domain
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ctrlMeta_r <= 1'b0;
      ctrlSync_r <= 1'b0;
    end
    else
    begin
      ctrlMeta_r <= ctrlRstN;
      ctrlSync_r <= ctrlMeta_r;
    end
  end

  // Core reset and run qualification
  assign coreReset = ~link.coreRstN | ((HAS_CTRL != 0) & ~ctrlSync_r);
  assign runEn = link.coreClkEn & ~coreReset;

  // Handshake terms; ready comes from held state only
  assign link.inReady = (count_r != FULL_COUNT);
  assign link.outValid = (count_r != '0);
  assign push = link.inValid & link.inReady & runEn;
  assign pop = link.outValid & link.outReady & runEn;

  // Only the low payload bits of the padded input word count
  assign inPix = link.inData[PW-1:0];

  // Pixel position from the built-in frame size
  always_comb
  begin
    curCol = link.pixInFrameStart ? '0 : col_r;
    curRow = link.pixInFrameStart ? '0 : row_r;
    lineEndCalc = (curCol == LAST_COL);
    frameEndCalc = lineEndCalc & (curRow == LAST_ROW);
  end

  // Position counters advance per accepted pixel
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      col_r <= '0;
      row_r <= '0;
    end
    else if (coreReset)
    begin
      col_r <= '0;
      row_r <= '0;
    end
    else if (push)
    begin
      col_r <= lineEndCalc ? '0 : curCol + 1'b1;
      if (frameEndCalc)
        row_r <= '0;
      else if (lineEndCalc)
        row_r <= curRow + 1'b1;
      else
        row_r <= curRow;
    end
  end

  // Line mark disagreement and frame completion events
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      lineErr_r <= 1'b0;
      frameDone_r <= 1'b0;
    end
    else if (coreReset)
    begin
      lineErr_r <= 1'b0;
      frameDone_r <= 1'b0;
    end
    else if (runEn)
    begin
      if (push && (link.inLineEnd != lineEndCalc))
        lineErr_r <= 1'b1;
      frameDone_r <= push & frameEndCalc;
    end
  end

  // Buffer storage, written only on an accepted pixel
  always_ff @(posedge clock)
  begin
    if (push)
      mem_r[wrPtr_r] <= {link.pixInFrameStart, lineEndCalc, inPix};
  end

  // Buffer occupancy
  always_comb
  begin
    count_nxt = count_r;
    if (push && !pop)
      count_nxt = count_r + 1'b1;
    else if (pop && !push)
      count_nxt = count_r - 1'b1;
  end

  // Buffer pointers and count; cleared by core reset, frozen while enable low
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else if (coreReset)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else if (runEn)
    begin
      if (push)
        wrPtr_r <= (wrPtr_r == LAST_SLOT) ? '0 : wrPtr_r + 1'b1;
      if (pop)
        rdPtr_r <= (rdPtr_r == LAST_SLOT) ? '0 : rdPtr_r + 1'b1;
      count_r <= count_nxt;
    end
  end

  // Head entry stays put until the sink takes it
  assign head = mem_r[rdPtr_r];

  // Per component pass through the conversion slot
  genvar c;
  generate
    for (c = 0; c < NUM_COMP; c++)
    begin : g_comp
      assign outPix[c*CW +: CW] = head[c*CW +: CW];
    end
  endgenerate

  // Output word with zero padding above the payload
  generate
    if (WW > PW)
    begin : g_pad
      assign link.outData = {{(WW-PW){1'b0}}, outPix};
    end
    else
    begin : g_nopad
      assign link.outData = outPix;
    end
  endgenerate
  assign link.pixOutFrameStart = head[PW+1] & link.outValid;
  assign link.outLineEnd = head[PW] & link.outValid;

  // Interrupt outputs exist only in their build options
  generate
    if (HAS_CTRL != 0)
    begin : g_irq
      assign irqReq = lineErr_r;
    end
    else
    begin : g_noirq
      assign irqReq = 1'b0;
    end
    if (HAS_INTC != 0)
    begin : g_intc
      always_comb
      begin
        extIrqCtrlBus = '0;
        extIrqCtrlBus[INTC_FRAME_DONE] = frameDone_r;
        extIrqCtrlBus[INTC_LINE_ERR] = lineErr_r;
      end
    end
    else
    begin : g_nointc
      assign extIrqCtrlBus = '0;
    end
  endgenerate

  // User side status
  assign colPos = col_r;
  assign rowPos = row_r;
  assign lineErr = lineErr_r;
endmodule
`default_nettype wire

// [shared/csc_stream_pkg.sv]
/*
  Shared constants, helper function and state type for both ends
  of the colour converter video stream link.
  Assumes a single core clock shared by both ends.
*/
`default_nettype none
package csc_stream_pkg;
  // Stream packing
  localparam int NUM_COMP = 3;
  localparam int COMP_W = 8;
  localparam int BYTE_W = 8;
  // Built-in frame size of the fixed configuration
  localparam int ACTIVE_COLS = 64;
  localparam int ACTIVE_ROWS = 48;
  // Buffer depth in the data path
  localparam int FIFO_DEPTH = 2;
  // Least core reset length in core clock cycles
  localparam int RST_HOLD_CYCLES = 32;
  // External interrupt controller bus layout
  localparam int INTC_W = 6;
  localparam int INTC_FRAME_DONE = 0;
  localparam int INTC_LINE_ERR = 1;
  // Sink ready policies
  localparam int READY_FREE = 0;
  localparam int READY_REGD = 1;

  // Word width: components packed, rounded up to whole bytes
  function automatic int csc_word_w(input int cw);
    return ((NUM_COMP * cw + BYTE_W - 1) / BYTE_W) * BYTE_W;
  endfunction

  // Source sequencer states
  typedef enum logic {SRC_IDLE, SRC_RUN} csc_src_e;
endpackage
`default_nettype wire

// [shared/csc_stream_if.sv]
/*
  Video stream link between the converter core and its peers:
  control levels, input stream and output stream.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface csc_stream_if
  import csc_stream_pkg::*;
#(
  parameter int DW = csc_word_w(COMP_W)
);
  // Core control levels
  logic coreClkEn;
  logic coreRstN;
  // Input stream, peer to core
  logic [DW-1:0] inData;
  logic inValid;
  logic inReady;
  logic pixInFrameStart;
  logic inLineEnd;
  // Output stream, core to peer
  logic [DW-1:0] outData;
  logic outValid;
  logic outReady;
  logic pixOutFrameStart;
  logic outLineEnd;

  // Converter core end
  modport dev (
    input coreClkEn, coreRstN,
    input inData, inValid, pixInFrameStart, inLineEnd,
    output inReady,
    output outData, outValid, pixOutFrameStart, outLineEnd,
    input outReady
  );

  // Upstream source, downstream sink and reset driver
  modport peer (
    output coreClkEn, coreRstN,
    output inData, inValid, pixInFrameStart, inLineEnd,
    input inReady,
    input outData, outValid, pixOutFrameStart, outLineEnd,
    output outReady
  );
endinterface
`default_nettype wire

// [rtl/csc_peer_end.sv]
/*
  Peer end of the video stream link: drives the core enable and the
  held core reset, sources test frames and sinks converted pixels.
  Assumes the same core clock as the converter core end.
*/
`timescale 1ns/1ps
`default_nettype none
module csc_peer_end
  import csc_stream_pkg::*;
#(
  parameter int CW = COMP_W,
  parameter int COLS = ACTIVE_COLS,
  parameter int ROWS = ACTIVE_ROWS,
  parameter int READY_MODE = READY_FREE
)(
  input wire logic clock,
  input wire logic rst,
  csc_stream_if.peer link,
  input wire logic coreEnable,
  input wire logic resetReq,
  input wire logic frameStart,
  input wire logic sinkStall,
  output logic busy,
  output logic frameSent,
  output logic [csc_word_w(CW)-1:0] rxData,
  output logic rxFrameStart,
  output logic rxLineEnd,
  output logic rxStrobe
);
  localparam int PW = NUM_COMP * CW;
  localparam int WW = csc_word_w(CW);
  localparam int XW = $clog2(COLS);
  localparam int YW = $clog2(ROWS);
  localparam int RW = $clog2(RST_HOLD_CYCLES + 1);
  localparam logic [RW-1:0] HOLD_END = RW'(RST_HOLD_CYCLES);
  localparam logic [RW-1:0] HOLD_LAST = RW'(RST_HOLD_CYCLES - 1);
  localparam logic [XW-1:0] LAST_COL = XW'(COLS - 1);
  localparam logic [YW-1:0] LAST_ROW = YW'(ROWS - 1);

  logic [RW-1:0] rstCnt_r;
  logic coreRstN_r;
  logic clkEn_r;
  csc_src_e state_r;
  logic [XW-1:0] col_r;
  logic [YW-1:0] row_r;
  logic valid_r;
  logic sof_r;
  logic last_r;
  logic [WW-1:0] data_r;
  logic [XW-1:0] colNext;
  logic [YW-1:0] rowNext;
  logic inTake;
  logic outTake;
  logic readyReg_r;

  // Test pixel: component c carries col + row + c, top bits zero
  function automatic logic [WW-1:0] make_pix(input logic [XW-1:0] x,
                                             input logic [YW-1:0] y);
    logic [WW-1:0] w;
    w = '0;
    for (int i = 0; i < NUM_COMP; i++)
      w[i*CW +: CW] = CW'(x) + CW'(y) + CW'(i);
    return w;
  endfunction

  // Core reset held low for the least length, synchronous output
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rstCnt_r <= '0;
      coreRstN_r <= 1'b0;
    end
    else if (resetReq)
    begin
      rstCnt_r <= '0;
      coreRstN_r <= 1'b0;
    end
    else if (rstCnt_r != HOLD_END)
    begin
      rstCnt_r <= rstCnt_r + 1'b1;
      coreRstN_r <= (rstCnt_r == HOLD_LAST);
    end
  end

  // Core enable follows the user level
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      clkEn_r <= 1'b0;
    else
      clkEn_r <= coreEnable;
  end
  assign link.coreClkEn = clkEn_r;
  assign link.coreRstN = coreRstN_r;

  // Transfers count only with enable high and reset released
  assign inTake = valid_r & link.inReady & clkEn_r & coreRstN_r;
  assign outTake = link.outValid & link.outReady & clkEn_r & coreRstN_r;

  // Next raster position
  always_comb
  begin
    colNext = (col_r == LAST_COL) ? '0 : col_r + 1'b1;
    rowNext = (col_r == LAST_COL) ? row_r + 1'b1 : row_r;
  end

  // Source: one frame of active pixels per start request
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_r <= SRC_IDLE;
      col_r <= '0;
      row_r <= '0;
      valid_r <= 1'b0;
      sof_r <= 1'b0;
      last_r <= 1'b0;
      data_r <= '0;
      frameSent <= 1'b0;
    end
    else if (!coreRstN_r)
    begin
      state_r <= SRC_IDLE;
      valid_r <= 1'b0;
      sof_r <= 1'b0;
      last_r <= 1'b0;
      frameSent <= 1'b0;
    end
    else
    begin
      frameSent <= 1'b0;
      case (state_r)
        SRC_IDLE:
        begin
          if (frameStart)
          begin
            state_r <= SRC_RUN;
            col_r <= '0;
            row_r <= '0;
            valid_r <= 1'b1;
            sof_r <= 1'b1;
            last_r <= (LAST_COL == '0);
            data_r <= make_pix('0, '0);
          end
        end
        SRC_RUN:
        begin
          if (inTake)
          begin
            if (last_r && (row_r == LAST_ROW))
            begin
              state_r <= SRC_IDLE;
              valid_r <= 1'b0;
              sof_r <= 1'b0;
              last_r <= 1'b0;
              frameSent <= 1'b1;
            end
            else
            begin
              col_r <= colNext;
              row_r <= rowNext;
              sof_r <= 1'b0;
              last_r <= (colNext == LAST_COL);
              data_r <= make_pix(colNext, rowNext);
            end
          end
        end
        default:
        begin
          state_r <= SRC_IDLE;
          valid_r <= 1'b0;
        end
      endcase
    end
  end
  assign link.inValid = valid_r;
  assign link.inData = data_r;
  assign link.pixInFrameStart = sof_r;
  assign link.inLineEnd = last_r;
  assign busy = (state_r == SRC_RUN);

  // Sink ready: free running or registered after valid
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      readyReg_r <= 1'b0;
    else
      readyReg_r <= link.outValid & ~sinkStall & ~outTake;
  end
  assign link.outReady = (READY_MODE == READY_REGD) ? readyReg_r
                                                    : ~sinkStall;

  // Sink capture of each accepted word
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rxData <= '0;
      rxFrameStart <= 1'b0;
      rxLineEnd <= 1'b0;
      rxStrobe <= 1'b0;
    end
    else
    begin
      rxStrobe <= outTake;
      if (outTake)
      begin
        rxData <= link.outData;
        rxFrameStart <= link.pixOutFrameStart;
        rxLineEnd <= link.outLineEnd;
      end
    end
  end
endmodule
`default_nettype wire

// [sim/csc_stream_assertions.sv]
/*
  Checker for the colour converter stream link: buffer flags, holds,
  freeze under enable, reset and frame marks.
  Assumes plain link signals on one core clock, rst async high.
*/
`timescale 1ns/1ps
`default_nettype none
module csc_stream_assertions
  import csc_stream_pkg::*;
#(
  parameter int DW = 24,
  parameter int COLS = ACTIVE_COLS,
  parameter int ROWS = ACTIVE_ROWS
)(
  input wire logic clock,
  input wire logic rst,
  input wire logic coreClkEn,
  input wire logic coreRstN,
  input wire logic [DW-1:0] inData,
  input wire logic inValid,
  input wire logic inReady,
  input wire logic pixInFrameStart,
  input wire logic inLineEnd,
  input wire logic [DW-1:0] outData,
  input wire logic outValid,
  input wire logic outReady,
  input wire logic pixOutFrameStart,
  input wire logic outLineEnd
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic inTake;
  logic outTake;
  logic [1:0] occ_r;
  logic [7:0] lowCnt_r;
  int col_r;
  int row_r;
  // Transfer qualifiers
  assign inTake = inValid && inReady && coreClkEn && coreRstN;
  assign outTake = outValid && outReady && coreClkEn && coreRstN;
  // Words held in the buffer
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      occ_r <= 2'h0;
    else if (!coreRstN)
      occ_r <= 2'h0;
    else
      occ_r <= occ_r + 2'(inTake) - 2'(outTake);
  end
  // Length of the core reset hold
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      lowCnt_r <= 8'h00;
    else if (coreRstN)
      lowCnt_r <= 8'h00;
    else if (lowCnt_r != 8'hFF)
      lowCnt_r <= lowCnt_r + 8'h01;
  end
  // Position of the next output pixel
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      col_r <= 0;
      row_r <= 0;
    end
    else if (!coreRstN)
    begin
      col_r <= 0;
      row_r <= 0;
    end
    else if (outTake)
    begin
      col_r <= (col_r == COLS - 1) ? 0 : col_r + 1;
      row_r <= (col_r != COLS - 1) ? row_r :
               (row_r == ROWS - 1) ? 0 : row_r + 1;
    end
  end
  a_buffer_flags: assert property (coreRstN |->
    inReady == (occ_r != FIFO_DEPTH) && outValid == (occ_r != 0))
    else $error("buffer flags disagree with fill level");
  a_fill_answer: assert property (inTake && !outValid |=>
    outValid && outData == $past(inData))
    else $error("accepted word not offered next cycle");
  a_out_hold: assert property (outValid && !outTake && coreRstN |=>
    outValid && $stable(outData) && $stable(pixOutFrameStart)
    && $stable(outLineEnd))
    else $error("output word changed before accepted");
  a_src_hold: assert property (inValid && !inTake && coreRstN |=>
    inValid && $stable(inData) && $stable(pixInFrameStart)
    && $stable(inLineEnd))
    else $error("input word changed before accepted");
  a_enable_freeze: assert property (!coreClkEn && coreRstN |=>
    $stable(inReady) && $stable(outValid) && $stable(outData))
    else $error("outputs moved with enable low");
  a_reset_clears: assert property (!coreRstN |=> inReady && !outValid)
    else $error("core reset did not clear buffer");
  a_reset_hold: assert property ($rose(coreRstN) |->
    lowCnt_r >= RST_HOLD_CYCLES)
    else $error("core reset released too early");
  a_line_end: assert property (outTake |->
    outLineEnd == (col_r == COLS - 1))
    else $error("line end on wrong pixel");
  a_frame_start: assert property (outTake |->
    pixOutFrameStart == (col_r == 0 && row_r == 0))
    else $error("frame start on wrong pixel");
  c_full: cover property (occ_r == 2'h2 && coreRstN);
  c_paused: cover property (!coreClkEn && outValid && coreRstN);
  c_sof: cover property (outTake && pixOutFrameStart);
  c_rst_end: cover property ($rose(coreRstN));
endmodule
`default_nettype wire

// [sim/tb.sv]
/*
  Self-checking bench: peer end and core end joined by the stream
  link, driven through the peer's user controls.
  Assumes package and interface compiled first, one 250 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import csc_stream_pkg::*;
  localparam int TC = 4;
  localparam int TR = 3;
  localparam int NPIX = TC * TR;
  localparam int DW = 24;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic coreEnable = 1'b0;
  logic resetReq = 1'b0;
  logic frameStart = 1'b0;
  logic sinkStall = 1'b0;
  logic stallOn = 1'b0;
  logic sawFull = 1'b0;
  logic busy, frameSent, rxFrameStart, rxLineEnd, rxStrobe;
  logic irqReq, lineErr;
  logic [DW-1:0] rxData;
  logic rx2FrameStart, rx2LineEnd, rx2Strobe;
  logic [DW-1:0] rx2Data;
  logic [INTC_W-1:0] extIrqCtrlBus;
  logic [1:0] colPos, rowPos;
  logic [DW-1:0] sb[$];
  int rxCnt = 0;
  int rx2Cnt = 0;
  int sentCnt = 0;
  int mismatches = 0;
  int cmp_count = 0;
  int held;
  csc_stream_if #(.DW(DW)) link();
  csc_stream_if #(.DW(DW)) link2();
  csc_core_end #(.COLS(TC), .ROWS(TR)) csc_core_end_inst (
    .clock(clock), .rst(rst), .link(link), .ctrlRstN(1'b1),
    .irqReq(irqReq), .extIrqCtrlBus(extIrqCtrlBus), .colPos(colPos),
    .rowPos(rowPos), .lineErr(lineErr));
  csc_peer_end #(.COLS(TC), .ROWS(TR)) csc_peer_end_inst (
    .clock(clock), .rst(rst), .link(link), .coreEnable(coreEnable),
    .resetReq(resetReq), .frameStart(frameStart), .sinkStall(sinkStall),
    .busy(busy), .frameSent(frameSent), .rxData(rxData),
    .rxFrameStart(rxFrameStart), .rxLineEnd(rxLineEnd),
    .rxStrobe(rxStrobe));
  csc_stream_assertions #(.DW(DW), .COLS(TC), .ROWS(TR)) chk_inst (
    .clock(clock), .rst(rst), .coreClkEn(link.coreClkEn),
    .coreRstN(link.coreRstN), .inData(link.inData),
    .inValid(link.inValid), .inReady(link.inReady),
    .pixInFrameStart(link.pixInFrameStart), .inLineEnd(link.inLineEnd),
    .outData(link.outData), .outValid(link.outValid),
    .outReady(link.outReady), .pixOutFrameStart(link.pixOutFrameStart),
    .outLineEnd(link.outLineEnd));
  // Second pair whose sink registers ready after valid
  csc_core_end #(.COLS(TC), .ROWS(TR)) csc_core_end_regd_inst (
    .clock(clock), .rst(rst), .link(link2), .ctrlRstN(1'b1),
    .irqReq(), .extIrqCtrlBus(), .colPos(), .rowPos(), .lineErr());
  csc_peer_end #(.COLS(TC), .ROWS(TR), .READY_MODE(READY_REGD))
    csc_peer_end_regd_inst (
    .clock(clock), .rst(rst), .link(link2), .coreEnable(coreEnable),
    .resetReq(resetReq), .frameStart(frameStart), .sinkStall(sinkStall),
    .busy(), .frameSent(), .rxData(rx2Data),
    .rxFrameStart(rx2FrameStart), .rxLineEnd(rx2LineEnd),
    .rxStrobe(rx2Strobe));
  // Core clock, 4 ns period
  always #2 clock = ~clock;
  // Receiver stall pattern
  always @(posedge clock)
    sinkStall <= stallOn && !sinkStall;
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // Pixel and marks expected for the n-th word at a sink
  task automatic check_rx(input int n, input logic [DW-1:0] d,
                          input logic sof, input logic line_end_flag);
    int x;
    int s;
    x = (n % NPIX) % TC;
    s = x + (n % NPIX) / TC;
    check("rxFrameStart", sof, n % NPIX == 0);
    check("rxLineEnd", line_end_flag, x == TC - 1);
    check("rxData", d, {COMP_W'(s + 2), COMP_W'(s + 1), COMP_W'(s)});
  endtask
  // Word scoreboard and receiver mark checks
  always @(posedge clock)
  begin
    if (!link.coreRstN)
      sb.delete();
    if (link.inValid && link.inReady && link.coreClkEn && link.coreRstN)
      sb.push_back(link.inData);
    if (link.outValid && link.outReady && link.coreClkEn && link.coreRstN)
      check("outData", link.outData, sb.pop_front());
    if (link.coreRstN && !link.inReady)
      sawFull <= 1'b1;
    if (frameSent === 1'b1)
      sentCnt++;
    if (rxStrobe === 1'b1)
    begin
      check_rx(rxCnt, rxData, rxFrameStart, rxLineEnd);
      rxCnt++;
    end
    if (rx2Strobe === 1'b1)
    begin
      check_rx(rx2Cnt, rx2Data, rx2FrameStart, rx2LineEnd);
      rx2Cnt++;
    end
    // Core reset restarts the frame count at each sink
    if (link.coreRstN === 1'b0)
      rxCnt = 0;
    if (link2.coreRstN === 1'b0)
      rx2Cnt = 0;
  end
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Waits for the core reset hold to end
  task automatic wait_up();
    int i;
    for (i = 0; i < 100 && link.coreRstN !== 1'b1; i++)
      @(negedge clock);
    check("core reset released", link.coreRstN, 1);
  endtask
  // Sends one frame and checks what came out
  task automatic run_frame(input string name, input logic stall);
    int base;
    int base2;
    int sent;
    int i;
    base = rxCnt;
    base2 = rx2Cnt;
    sent = sentCnt;
    @(posedge clock);
    stallOn <= stall;
    frameStart <= 1'b1;
    @(posedge clock);
    frameStart <= 1'b0;
    for (i = 0; i < 400 && (rxCnt - base < NPIX || rx2Cnt - base2 < NPIX);
         i++)
      @(posedge clock);
    stallOn <= 1'b0;
    @(negedge clock);
    check("pixel count", rxCnt - base, NPIX);
    check("regd pixel count", rx2Cnt - base2, NPIX);
    check("frames sent", sentCnt - sent, 1);
    check("lineErr", lineErr, 0);
    check("interrupt outputs", {irqReq, extIrqCtrlBus}, 0);
    $display("test %s done", name);
  endtask
  // Watchdog
  initial
  begin
    #40000;
    mismatches++;
    give_verdict();
  end
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    coreEnable <= 1'b1;
    wait_up();
    run_frame("free sink", 1'b0);
    run_frame("back to back", 1'b0);
    run_frame("stalled sink", 1'b1);
    check("buffer full seen", sawFull, 1);
    fork
      run_frame("enable pause", 1'b0);
      begin
        repeat (5) @(posedge clock);
        coreEnable <= 1'b0;
        repeat (4) @(posedge clock);
        held = rxCnt;
        repeat (8) @(posedge clock);
        check("count while disabled", rxCnt, held);
        coreEnable <= 1'b1;
      end
    join
    // Core reset in mid frame
    @(posedge clock);
    frameStart <= 1'b1;
    @(posedge clock);
    frameStart <= 1'b0;
    repeat (6) @(posedge clock);
    @(negedge clock);
    check("busy in frame", busy, 1);
    check("positions in frame", {colPos, rowPos} != 0, 1);
    @(posedge clock);
    resetReq <= 1'b1;
    @(posedge clock);
    resetReq <= 1'b0;
    repeat (3) @(negedge clock);
    check("core reset level", link.coreRstN, 0);
    check("positions", {colPos, rowPos}, 0);
    check("busy after reset", busy, 0);
    $display("test mid frame reset done");
    wait_up();
    run_frame("after reset", 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
